// [verilog/serial_adc_pkg.sv]
// Package: constants for the serial converter interface
package serial_adc_pkg;
   localparam int clock_period_ns = 25;
   localparam int exchange_bits = 8;
   localparam int address_bits = 5;
   localparam int conv_min_cycles = 26;
   localparam int conv_max_cycles = 32;
   localparam int conv_cycles = conv_max_cycles;
   localparam int phase_divide = 20;
   localparam int setup_phase_cycles = 4;
   localparam logic [4:0] last_channel_code = 5'h12;
   localparam logic [4:0] check_voltage_code = 5'h13;
   localparam logic [1:0] test_mode_prefix = 2'h3;
   localparam logic [4:0] addr_reset = 5'h00;
   localparam logic [7:0] result_reset = 8'h00;
   localparam int fifo_width = 8;
   localparam int fifo_depth = 16;
endpackage

// [verilog/result_fifo.sv]
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module result_fifo #(
   parameter int width = 8,
   parameter int depth = 16
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [width-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [width-1:0] out_data
);
   localparam int aw = $clog2(depth);
   logic [width-1:0] mem [depth];
   logic [aw:0] wp_reg, wp_next, rp_reg, rp_next;
   logic push, pop;

   always_comb begin
      in_ready = (wp_reg - rp_reg) != (aw+1)'(depth);
      out_valid = wp_reg != rp_reg;
      out_data = mem[rp_reg[aw-1:0]];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wp_next = push ? wp_reg + 1'b1 : wp_reg;
      rp_next = pop ? rp_reg + 1'b1 : rp_reg;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
      end
   end

   // Storage has no reset; pointers guard it
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wp_reg[aw-1:0]] <= in_data;
      end
   end
endmodule

// [verilog/serial_adc_mux_interface.sv]
// Serial control, channel decode and conversion sequencing of the converter
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - With select high, serial input, output and clock are ignored or off.
// - Address captured on rising serial edges, result on falling; eight cycles.
// - Select pulses shorter than one conversion clock are ignored.
// - Select falling edge recognised two to three conversion clocks later.
// - Select falling edge drives the previous result MSB at once.
// - First rising serial edge accepted only after a setup delay.
// - First five cycles load the address; last three sample.
// - Decode address into channels, check voltage, none, or test mode.
// - Remaining seven result bits go out on next seven falling edges.
// - Eighth falling edge starts a conversion of 26 to 32 clocks.
// - Select high during conversion releases output; conversion continues.
// - Select low through conversion waits, then starts the next exchange.
// - A recognised select strobe aborts and starts a fresh exchange.
// - After an abort, output data invalid until one full conversion.
// - Result survives select high during conversion until it ends.
// - Each completed read-out consumes the result; a new conversion follows.
module serial_adc_mux_interface (
   input wire logic clock,
   input wire logic rstn,
   input wire logic select_n,
   input wire logic serial_clock,
   input wire logic serial_address_in,
   output logic serial_data_out,
   output logic serial_data_oe,
   input wire logic [7:0] sample_value,
   output logic [4:0] channel_select,
   output logic channel_enable,
   output logic check_voltage_select,
   output logic logic_test_mode,
   output logic sampling,
   output logic result_valid,
   output logic [7:0] result_data,
   input wire logic result_ready
);
   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_shift = 4'h2,
      st_convert = 4'h4,
      st_hold = 4'h8
   } state_t;

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] cs_sync_reg, sck_sync_reg, di_sync_reg;
   logic sck_last_reg, cs_last_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cs_sync_reg <= 2'h3;
         sck_sync_reg <= 2'h0;
         di_sync_reg <= 2'h0;
         sck_last_reg <= 1'b0;
         cs_last_reg <= 1'b1;
      end else begin
         cs_sync_reg <= {cs_sync_reg[0], select_n};
         sck_sync_reg <= {sck_sync_reg[0], serial_clock};
         di_sync_reg <= {di_sync_reg[0], serial_address_in};
         sck_last_reg <= sck_sync_reg[1];
         cs_last_reg <= cs_sync_reg[1];
      end
   end
   logic cs_raw, sck_rise, sck_fall, di_bit;
   assign cs_raw = cs_sync_reg[1];
   assign sck_rise = sck_sync_reg[1] && !sck_last_reg;
   assign sck_fall = !sck_sync_reg[1] && sck_last_reg;
   assign di_bit = di_sync_reg[1];

   //////////////////////////////////////////////////////////////////////////
   // Conversion clock enable from divider
   logic [4:0] div_reg, div_next;
   logic phase_tick;
   always_comb begin
      phase_tick = div_reg == 5'(serial_adc_pkg::phase_divide - 1);
      div_next = phase_tick ? 5'h00 : div_reg + 5'h01;
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_reg <= 5'h00;
      end else begin
         div_reg <= div_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Select filter on conversion clock ticks
   logic [1:0] cs_stage_reg, cs_stage_next;
   logic cs_filt_reg, cs_filt_next;
   always_comb begin
      cs_stage_next = cs_stage_reg;
      cs_filt_next = cs_filt_reg;
      if (phase_tick) begin
         cs_stage_next = {cs_stage_reg[0], cs_raw};
         // Level must persist two ticks, rejects sub-period spikes
         if (cs_stage_reg[1] == cs_stage_reg[0]) begin
            cs_filt_next = cs_stage_reg[1];
         end
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cs_stage_reg <= 2'h3;
         cs_filt_reg <= 1'b1;
      end else begin
         cs_stage_reg <= cs_stage_next;
         cs_filt_reg <= cs_filt_next;
      end
   end
   logic cs_filt_last_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cs_filt_last_reg <= 1'b1;
      end else begin
         cs_filt_last_reg <= cs_filt_reg;
      end
   end
   logic cs_recognised;
   assign cs_recognised = cs_filt_last_reg && !cs_filt_reg;

   //////////////////////////////////////////////////////////////////////////
   // Exchange and conversion sequencer
   state_t state_reg, state_next;
   logic [3:0] bit_reg, bit_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] result_reg, result_next;
   logic [4:0] addr_reg, addr_next;
   logic [5:0] cnt_reg, cnt_next;
   logic [2:0] setup_reg, setup_next;
   logic good_reg, good_next;
   logic dout_reg, dout_next;
   logic oe_reg, oe_next;
   logic push_reg, push_next;
   logic fifo_ready;

   always_comb begin
      state_next = state_reg;
      bit_next = bit_reg;
      shift_next = shift_reg;
      result_next = result_reg;
      addr_next = addr_reg;
      cnt_next = cnt_reg;
      setup_next = setup_reg;
      good_next = good_reg;
      dout_next = dout_reg;
      oe_next = !cs_raw;
      push_next = 1'b0;
      // Edge taken after the second stage only, never from the first
      if (cs_last_reg && !cs_raw) begin
         // Raw falling select edge shows the MSB before filtering settles
         dout_next = result_reg[7];
      end
      case (state_reg)
         st_idle: begin
            if (cs_recognised) begin
               state_next = st_shift;
            end
         end
         st_shift: begin
            if (phase_tick && setup_reg != 3'(serial_adc_pkg::setup_phase_cycles)) begin
               setup_next = setup_reg + 3'h1;
            end
            // Setup gate on rising edges
            if (!cs_raw && sck_rise
                && setup_reg == 3'(serial_adc_pkg::setup_phase_cycles)) begin
               if (bit_reg < 4'(serial_adc_pkg::address_bits)) begin
                  addr_next = {addr_reg[3:0], di_bit};
               end
            end
            if (!cs_raw && sck_fall
                && setup_reg == 3'(serial_adc_pkg::setup_phase_cycles)) begin
               bit_next = bit_reg + 4'h1;
               shift_next = {shift_reg[6:0], 1'b0};
               dout_next = shift_reg[6];
               if (bit_reg == 4'(serial_adc_pkg::exchange_bits - 1)) begin
                  state_next = st_convert;
                  cnt_next = 6'h00;
                  if (good_reg && fifo_ready) begin
                     push_next = 1'b1;
                  end
               end
            end
         end
         st_convert: begin
            if (phase_tick) begin
               cnt_next = cnt_reg + 6'h01;
            end
            // Fixed worst-case length, inside the 26 to 32 window
            if (phase_tick && cnt_reg == 6'(serial_adc_pkg::conv_cycles - 1)) begin
               result_next = sample_value;
               good_next = 1'b1;
               state_next = cs_raw ? st_idle : st_hold;
            end
         end
         st_hold: begin
            state_next = st_shift;
         end
         default: begin
            state_next = st_idle;
         end
      endcase
      if (state_reg == st_hold || (state_reg == st_idle && cs_recognised)) begin
         bit_next = 4'h0;
         shift_next = result_reg;
         dout_next = result_reg[7];
         setup_next = (state_reg == st_hold)
            ? 3'(serial_adc_pkg::setup_phase_cycles) : 3'h0;
      end
      if (cs_recognised && state_reg != st_idle) begin
         state_next = st_shift;
         bit_next = 4'h0;
         shift_next = result_reg;
         setup_next = 3'h0;
         good_next = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= st_idle;
         bit_reg <= 4'h0;
         shift_reg <= serial_adc_pkg::result_reset;
         result_reg <= serial_adc_pkg::result_reset;
         addr_reg <= serial_adc_pkg::addr_reset;
         cnt_reg <= 6'h00;
         setup_reg <= 3'h0;
         good_reg <= 1'b0;
         dout_reg <= 1'b0;
         oe_reg <= 1'b0;
         push_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         result_reg <= result_next;
         addr_reg <= addr_next;
         cnt_reg <= cnt_next;
         setup_reg <= setup_next;
         good_reg <= good_next;
         dout_reg <= dout_next;
         oe_reg <= oe_next;
         push_reg <= push_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Address decode
   logic [4:0] chan_reg, chan_next;
   logic en_reg, en_next, chk_reg, chk_next, tst_reg, tst_next, smp_reg, smp_next;
   always_comb begin
      chan_next = addr_reg;
      en_next = addr_reg <= serial_adc_pkg::last_channel_code;
      chk_next = addr_reg == serial_adc_pkg::check_voltage_code;
      tst_next = addr_reg[4:3] == serial_adc_pkg::test_mode_prefix;
      smp_next = state_reg == st_shift
         && bit_reg >= 4'(serial_adc_pkg::address_bits);
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         chan_reg <= serial_adc_pkg::addr_reset;
         en_reg <= 1'b0;
         chk_reg <= 1'b0;
         tst_reg <= 1'b0;
         smp_reg <= 1'b0;
      end else begin
         chan_reg <= chan_next;
         en_reg <= en_next;
         chk_reg <= chk_next;
         tst_reg <= tst_next;
         smp_reg <= smp_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Result stream; a full FIFO drops the result rather than stall the pins
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic rv_reg, rv_next;
   logic [7:0] rd_reg, rd_next;
   result_fifo #(
      .width(serial_adc_pkg::fifo_width),
      .depth(serial_adc_pkg::fifo_depth)
   ) u_fifo (
      .clock(clock),
      .rstn(rstn),
      .in_valid(push_reg),
      .in_ready(fifo_ready),
      .in_data(result_reg),
      .out_valid(fifo_valid),
      // Pop exactly when the output stage loads, else the head repeats
      .out_ready(!rv_reg || result_ready),
      .out_data(fifo_data)
   );
   always_comb begin
      rv_next = rv_reg;
      rd_next = rd_reg;
      if (!rv_reg || result_ready) begin
         rv_next = fifo_valid;
         rd_next = fifo_data;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rv_reg <= 1'b0;
         rd_reg <= serial_adc_pkg::result_reset;
      end else begin
         rv_reg <= rv_next;
         rd_reg <= rd_next;
      end
   end

   assign serial_data_out = dout_reg;
   assign serial_data_oe = oe_reg;
   assign channel_select = chan_reg;
   assign channel_enable = en_reg;
   assign check_voltage_select = chk_reg;
   assign logic_test_mode = tst_reg;
   assign sampling = smp_reg;
   assign result_valid = rv_reg;
   assign result_data = rd_reg;

   //////////////////////////////////////////////////////////////////////////
   // Checks
   a_output_release: assert property (@(posedge clock) disable iff (!rstn)
      cs_raw |=> !serial_data_oe) else $error("output driven with select high");
   a_test_decode: assert property (@(posedge clock) disable iff (!rstn)
      addr_reg[4:3] == 2'h3 |=> logic_test_mode) else $error("test mode missed");
   a_channel_decode: assert property (@(posedge clock) disable iff (!rstn)
      addr_reg == 5'h13 |=> check_voltage_select && !channel_enable)
      else $error("check voltage decode wrong");
   a_conv_length: assert property (@(posedge clock) disable iff (!rstn)
      $rose(state_reg == st_convert) && !cs_recognised |-> (state_reg == st_convert)[*8])
      else $error("conversion ended early");
   a_conv_bound: assert property (@(posedge clock) disable iff (!rstn)
      state_reg == st_convert |-> cnt_reg <= 6'h20) else $error("conversion overran");
   a_abort_fresh: assert property (@(posedge clock) disable iff (!rstn)
      cs_recognised |=> state_reg == st_shift && bit_reg == 4'h0)
      else $error("abort did not restart");
   a_abort_invalid: assert property (@(posedge clock) disable iff (!rstn)
      cs_recognised && state_reg != st_idle |=> !good_reg)
      else $error("data still valid after abort");
   a_setup_gate: assert property (@(posedge clock) disable iff (!rstn)
      state_reg == st_shift && setup_reg != 3'h4 |=> $stable(addr_reg))
      else $error("address taken before setup");
   a_filter_spike: assert property (@(posedge clock) disable iff (!rstn)
      $fell(cs_filt_reg) |-> cs_stage_reg[1] == 1'b0)
      else $error("filter passed spike");
   a_msb_first: assert property (@(posedge clock) disable iff (!rstn)
      state_reg == st_hold |=> serial_data_out == shift_reg[7])
      else $error("msb not presented");
endmodule

// [test/serial_host_model.sv]
// Host-side model of the serial controller facing the converter
`timescale 1ns/1ps
module serial_host_model (
   input wire logic clock,
   output logic select_n,
   output logic serial_clock,
   output logic serial_address_in,
   input wire logic serial_data_out,
   input wire logic serial_data_oe
);
   logic last_bit;
   logic line_level;
   // A released line shows the inverse, so a stale bit never passes
   assign line_level = serial_data_oe ? serial_data_out : ~last_bit;
   always @(posedge clock) begin
      if (serial_data_oe) begin
         last_bit <= serial_data_out;
      end
   end
   initial begin
      last_bit = 1'b0;
      select_n = 1'b1;
      serial_clock = 1'b0;
      serial_address_in = 1'b0;
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock);
   endtask
   // 200 clocks covers filtered recognition plus the four-tick setup
   task automatic drop_select(input int n);
      select_n = 1'b0;
      wait_clk(n);
   endtask
   task automatic raise_select(input int hold);
      select_n = 1'b1;
      wait_clk(hold);
   endtask
   // Select is not driven here; it keeps the caller's level for the whole frame
   task automatic shift_bits(input logic [4:0] addr, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      for (int i = 0; i < nbits; i++) begin
         serial_address_in = (i < 5) ? addr[4 - i] : 1'b0;
         wait_clk(4);
         serial_clock = 1'b1;
         wait_clk(3);
         rd[7 - i] = line_level;
         wait_clk(1);
         serial_clock = 1'b0;
      end
      // Clock parks low between frames
      serial_address_in = ~serial_address_in;
      wait_clk(4);
   endtask
endmodule

// [test/serial_adc_mux_interface_tb.sv]
// Self-checking bench for the serial converter interface
`timescale 1ns/1ps
`define check_eq(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("MISMATCH at %0t: got %0h expected %0h", $time, (got), (exp)); \
      end \
   end
module serial_adc_mux_interface_tb;
   logic clock;
   logic rstn;
   logic select_n;
   logic serial_clock;
   logic serial_address_in;
   logic serial_data_out;
   logic serial_data_oe;
   logic [7:0] sample_value;
   logic [4:0] channel_select;
   logic channel_enable;
   logic check_voltage_select;
   logic logic_test_mode;
   logic sampling;
   logic result_valid;
   logic [7:0] result_data;
   logic result_ready;
   int num_errors;
   int checks;
   logic [7:0] prev;
   logic [7:0] rd;
   logic [4:0] last_a;
   serial_adc_mux_interface u_serial_adc_mux_interface (
      .clock(clock),
      .rstn(rstn),
      .select_n(select_n),
      .serial_clock(serial_clock),
      .serial_address_in(serial_address_in),
      .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe),
      .sample_value(sample_value),
      .channel_select(channel_select),
      .channel_enable(channel_enable),
      .check_voltage_select(check_voltage_select),
      .logic_test_mode(logic_test_mode),
      .sampling(sampling),
      .result_valid(result_valid),
      .result_data(result_data),
      .result_ready(result_ready)
   );
   serial_host_model u_serial_host_model (
      .clock(clock),
      .select_n(select_n),
      .serial_clock(serial_clock),
      .serial_address_in(serial_address_in),
      .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe)
   );
   // Free-running, the conversion tick derives from it
   always #12.5 clock = ~clock;
   //////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (num_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // One full frame, select raised at once, hold past 32 ticks
   task automatic do_xfer(input logic [4:0] a, input logic [7:0] s, input bit chk);
      sample_value = s;
      u_serial_host_model.drop_select(200);
      u_serial_host_model.shift_bits(a, 8, rd);
      u_serial_host_model.raise_select(6);
      `check_eq(serial_data_oe, 1'b0)
      u_serial_host_model.wait_clk(800);
      if (chk) `check_eq(rd, prev)
      `check_eq(channel_select, a)
      `check_eq(sampling, 1'b0)
      `check_eq(channel_enable, a <= serial_adc_pkg::last_channel_code)
      `check_eq(check_voltage_select, a == serial_adc_pkg::check_voltage_code)
      `check_eq(logic_test_mode, a[4:3] == serial_adc_pkg::test_mode_prefix)
      prev = s;
      last_a = a;
   endtask
   task automatic t_decode();
      logic [4:0] codes [7] = '{5'h05, 5'h12, 5'h13, 5'h14, 5'h17, 5'h18, 5'h00};
      for (int i = 0; i < 7; i++) begin
         do_xfer(codes[i], {3'h5, codes[i]}, i > 0);
      end
   endtask
   // Short low pulse shows the MSB but must not start or consume a frame
   task automatic t_glitch();
      u_serial_host_model.drop_select(5);
      `check_eq(serial_data_oe, 1'b1)
      `check_eq(serial_data_out, prev[7])
      u_serial_host_model.wait_clk(5);
      u_serial_host_model.raise_select(100);
      do_xfer(5'h01, 8'h3C, 1);
   endtask
   task automatic t_ignored();
      u_serial_host_model.shift_bits(5'h1F, 8, rd);
      `check_eq(channel_select, last_a)
      `check_eq(serial_data_oe, 1'b0)
      do_xfer(5'h02, 8'hC3, 1);
   endtask
   // Abort, gated frames, then overfill the FIFO with the sink stalled
   task automatic t_abort_fill();
      logic [7:0] got [20];
      int cnt;
      result_ready = 1'b0;
      u_serial_host_model.drop_select(200);
      u_serial_host_model.shift_bits(5'h03, 6, rd);
      `check_eq(sampling, 1'b1)
      u_serial_host_model.raise_select(100);
      do_xfer(5'h04, 8'h9A, 0);
      `check_eq(result_valid, 1'b0)
      sample_value = 8'h6B;
      u_serial_host_model.drop_select(200);
      u_serial_host_model.shift_bits(5'h05, 8, rd);
      `check_eq(rd, 8'h9A)
      u_serial_host_model.wait_clk(700);
      u_serial_host_model.shift_bits(5'h06, 8, rd);
      `check_eq(rd, 8'h6B)
      u_serial_host_model.raise_select(800);
      prev = 8'h6B;
      for (int i = 0; i < 16; i++) begin
         do_xfer(5'h07, 8'h40 + 8'(i), 1);
      end
      result_ready = 1'b1;
      cnt = 0;
      for (int n = 0; n < 60; n++) begin
         if (result_valid === 1'b1 && cnt < 20) begin
            got[cnt] = result_data;
            cnt++;
         end
         @(negedge clock);
      end
      // Output stage holds one beyond the 16 queued; the last push drops
      `check_eq(cnt, 17)
      `check_eq(got[0], 8'h9A)
      `check_eq(got[1], 8'h6B)
      `check_eq(got[2], 8'h6B)
      `check_eq(got[15], 8'h4C)
      `check_eq(got[16], 8'h4D)
   endtask
   initial begin
      #2000000;
      num_errors++;
      give_verdict();
   end
   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      sample_value = 8'h00;
      result_ready = 1'b1;
      num_errors = 0;
      checks = 0;
      prev = 8'h00;
      last_a = 5'h00;
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      @(negedge clock);
      `check_eq(serial_data_oe, 1'b0)
      `check_eq(result_valid, 1'b0)
      t_decode();
      t_glitch();
      t_ignored();
      t_abort_fill();
      give_verdict();
   end
endmodule
